// [src/dps_pkg.sv]
// shared constants and helpers for the burst sram link
package dps_pkg;
   localparam int DPS_DATA_W = 36;
   localparam int DPS_ADDR_W = 20;
   localparam int DPS_LANES = 4;
   localparam int DPS_LANE_W = 9;
   localparam int DPS_BANK_DEPTH = 2 ** DPS_ADDR_W;
   localparam int DPS_CLK_NS = 25;
   localparam int DPS_LINK_PERIOD_NS = 200;
   localparam int DPS_K_HALF_CYC = DPS_LINK_PERIOD_NS / (2 * DPS_CLK_NS);
   localparam logic [2:0] DPS_K_HALF = 3'(DPS_K_HALF_CYC);
   localparam logic [2:0] DPS_PH_LAST = 3'(2 * DPS_K_HALF_CYC - 1);
   localparam logic [2:0] DPS_PH_POS_SETUP = 3'h6;
   localparam logic [2:0] DPS_PH_NEG_SETUP = 3'h2;
   localparam int DPS_SLOTS = 4;
   localparam logic [1:0] DPS_FIRST_SLOT_PLL = 2'h2;
   localparam logic [1:0] DPS_FIRST_SLOT_SINGLE = 2'h1;
   localparam int DPS_FIFO_DEPTH = 4;
   localparam int DPS_WR_W = DPS_ADDR_W + 2 * DPS_DATA_W + 2 * DPS_LANES;
   localparam int DPS_SYNC_W = 7 + DPS_LANES + DPS_ADDR_W + DPS_DATA_W;

   // lanes whose select is low take the new data, others keep the old
   function automatic logic [DPS_DATA_W-1:0] dps_merge(
      input logic [DPS_DATA_W-1:0] old_w,
      input logic [DPS_DATA_W-1:0] new_w,
      input logic [DPS_LANES-1:0] sel_n);
      logic [DPS_DATA_W-1:0] r;
      r = old_w;
      for (int i = 0; i < DPS_LANES; i++) begin
         if (!sel_n[i]) begin
            r[i*DPS_LANE_W +: DPS_LANE_W] = new_w[i*DPS_LANE_W +: DPS_LANE_W];
         end
      end
      return r;
   endfunction : dps_merge
endpackage : dps_pkg

// [src/dps_link_if.sv]
// pin bundle between the memory end and the controller end
`timescale 1ns/1ps
`default_nettype none
interface dps_link_if;
   import dps_pkg::*;
   logic k;
   logic k_n;
   logic c;
   logic c_n;
   logic [DPS_ADDR_W-1:0] addr;
   logic read_port_select_n;
   logic write_port_select_n;
   logic [DPS_LANES-1:0] lane_write_enable_n;
   logic [DPS_DATA_W-1:0] d;
   logic [DPS_DATA_W-1:0] q;
   logic q_oe;
   logic echo_strobe_p;
   logic echo_strobe_n;
   logic pll_disable_n;

   modport mem (
      input k, k_n, c, c_n, addr, read_port_select_n, write_port_select_n,
      input lane_write_enable_n, d, pll_disable_n,
      output q, q_oe, echo_strobe_p, echo_strobe_n
   );
   modport ctrl (
      output k, k_n, c, c_n, addr, read_port_select_n, write_port_select_n,
      output lane_write_enable_n, d, pll_disable_n,
      input q, q_oe, echo_strobe_p, echo_strobe_n
   );
endinterface : dps_link_if
`default_nettype wire

// [src/dps_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dps_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem_ff [DEPTH];
   logic [PW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
   logic [PW:0] cnt_ff, nxt_cnt;
   logic push, pop;

   assign in_ready = (cnt_ff != (PW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rp_ff];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      nxt_wp = wp_ff;
      nxt_rp = rp_ff;
      nxt_cnt = cnt_ff;
      if (push) begin
         nxt_wp = (wp_ff == PW'(DEPTH - 1)) ? '0 : PW'(wp_ff + 1'b1);
      end
      if (pop) begin
         nxt_rp = (rp_ff == PW'(DEPTH - 1)) ? '0 : PW'(rp_ff + 1'b1);
      end
      if (push && !pop) begin
         nxt_cnt = (PW+1)'(cnt_ff + 1'b1);
      end else if (pop && !push) begin
         nxt_cnt = (PW+1)'(cnt_ff - 1'b1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         cnt_ff <= nxt_cnt;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wp_ff] <= in_data;
      end
   end
endmodule : dps_fifo
`default_nettype wire

// [src/dps_mem_end.sv]
// memory end: double-rate burst sram seen at its pins
//
// Function
// R1 - each low lane select gates one 9-bit lane
// R2 - deselected lane keeps stored byte unchanged
// R3 - lane selects sampled with their data word
// R4 - read address on k, write on k_n
// R5 - two banks, 20-bit address at 36 bits
// R6 - address ignored when its port deselected
// R7 - read words launched on c/c_n edges
// R8 - outputs released when no read selected
// R9 - read select sampled on k rise
// R10 - pending read finishes before output release
// R11 - each read returns two sequential words
// R12 - every access starts on k rise
// R13 - k_n rise also captures inputs
// R14 - echo strobes follow output clock, free running
// R15 - controller drives c and c_n together
// R16 - write data sampled on k and k_n
// R17 - write select on k rise, else ignored
// R18 - pll off gives one-cycle read latency
// R19 - pll on gives 1.5-cycle read latency
// R20 - write is two words, k then k_n
`timescale 1ns/1ps
`default_nettype none
module dps_mem_end
   import dps_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   dps_link_if.mem lnk
);
   // all pins share one two-stage path so data stays aligned to clocks
   logic [DPS_SYNC_W-1:0] pins;
   logic [DPS_SYNC_W-1:0] meta_ff;
   logic [DPS_SYNC_W-1:0] smp_ff;
   logic [3:0] clk_prev_ff;

   assign pins = {lnk.k, lnk.k_n, lnk.c, lnk.c_n,
                  lnk.read_port_select_n, lnk.write_port_select_n,
                  lnk.pll_disable_n, lnk.lane_write_enable_n,
                  lnk.addr, lnk.d};

   // not reset: the path fills with idle pin levels while reset is held,
   // so no false clock edge is seen on release
   always_ff @(posedge clk) begin
      meta_ff <= pins;
      smp_ff <= meta_ff;
      clk_prev_ff <= smp_ff[DPS_SYNC_W-1 -: 4];
   end

   logic k_s, kn_s, c_s, cn_s;
   logic rps_s, wps_s, pll_s;
   logic [DPS_LANES-1:0] lane_s;
   logic [DPS_ADDR_W-1:0] addr_s;
   logic [DPS_DATA_W-1:0] d_s;

   assign {k_s, kn_s, c_s, cn_s, rps_s, wps_s, pll_s, lane_s, addr_s, d_s} = smp_ff;

   logic k_rise, kn_rise, c_rise, cn_rise;
   logic single_mode, launch;
   logic rd_go, wr_go, wr_fin;

   assign k_rise = k_s & ~clk_prev_ff[3];
   assign kn_rise = kn_s & ~clk_prev_ff[2];
   assign c_rise = c_s & ~clk_prev_ff[1];
   assign cn_rise = cn_s & ~clk_prev_ff[0];
   // c and c_n held high together marks single clock mode
   assign single_mode = c_s & cn_s;
   assign launch = single_mode ? (k_rise | kn_rise) : (c_rise | cn_rise); // [R7] [R13]
   assign rd_go = k_rise & ~rps_s; // [R9] [R12] [R4] [R6]
   assign wr_go = k_rise & ~wps_s; // [R17] [R12]

   // ---------------- storage ----------------
   // two banks: even word at bank_even, odd word at bank_odd
   logic [DPS_DATA_W-1:0] bank_even [DPS_BANK_DEPTH]; // [R5]
   logic [DPS_DATA_W-1:0] bank_odd [DPS_BANK_DEPTH];
   logic [DPS_DATA_W-1:0] rd_word0, rd_word1;

   assign rd_word0 = bank_even[addr_s]; // [R11]
   assign rd_word1 = bank_odd[addr_s];

   // ---------------- write path ----------------
   logic wr_act_ff, nxt_wr_act;
   logic [DPS_DATA_W-1:0] wd0_ff, nxt_wd0;
   logic [DPS_LANES-1:0] wb0_ff, nxt_wb0;

   assign wr_fin = kn_rise & wr_act_ff; // [R4] [R6] [R13]

   always_comb begin
      nxt_wr_act = wr_act_ff;
      nxt_wd0 = wd0_ff;
      nxt_wb0 = wb0_ff;
      if (wr_go) begin
         nxt_wr_act = 1'b1;
         nxt_wd0 = d_s; // [R16] [R20]
         nxt_wb0 = lane_s; // [R3]
      end else if (wr_fin) begin
         nxt_wr_act = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_act_ff <= 1'b0;
         wd0_ff <= '0;
         wb0_ff <= '1;
      end else begin
         wr_act_ff <= nxt_wr_act;
         wd0_ff <= nxt_wd0;
         wb0_ff <= nxt_wb0;
      end
   end

   // both words of the burst land together once the address is known
   always_ff @(posedge clk) begin
      if (wr_fin) begin
         bank_even[addr_s] <= dps_merge(bank_even[addr_s], wd0_ff, wb0_ff); // [R1] [R2]
         bank_odd[addr_s] <= dps_merge(bank_odd[addr_s], d_s, lane_s); // [R3] [R16] [R20]
      end
   end

   // ---------------- read path ----------------
   // slot 0 leaves on the next launch edge; latency is counted in launch
   // edges strictly after the capture
   logic slot_v_ff [DPS_SLOTS];
   logic [DPS_DATA_W-1:0] slot_d_ff [DPS_SLOTS];
   logic nxt_slot_v [DPS_SLOTS];
   logic [DPS_DATA_W-1:0] nxt_slot_d [DPS_SLOTS];
   logic [DPS_DATA_W-1:0] q_ff, nxt_q;
   logic oe_ff, nxt_oe;
   logic [1:0] first_slot, second_slot;

   assign first_slot = pll_s ? DPS_FIRST_SLOT_PLL : DPS_FIRST_SLOT_SINGLE; // [R18] [R19]
   assign second_slot = 2'(first_slot + 2'h1);

   always_comb begin
      nxt_slot_v = slot_v_ff;
      nxt_slot_d = slot_d_ff;
      nxt_q = q_ff;
      nxt_oe = oe_ff;
      if (launch) begin
         nxt_q = slot_d_ff[0]; // [R7]
         // an empty slot releases the pins, after any pending words left
         nxt_oe = slot_v_ff[0]; // [R8] [R10]
         for (int i = 0; i < DPS_SLOTS - 1; i++) begin
            nxt_slot_v[i] = slot_v_ff[i+1];
            nxt_slot_d[i] = slot_d_ff[i+1];
         end
         nxt_slot_v[DPS_SLOTS-1] = 1'b0;
         nxt_slot_d[DPS_SLOTS-1] = '0;
      end
      if (rd_go) begin
         nxt_slot_v[first_slot] = 1'b1; // [R11]
         nxt_slot_d[first_slot] = rd_word0;
         nxt_slot_v[second_slot] = 1'b1;
         nxt_slot_d[second_slot] = rd_word1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < DPS_SLOTS; i++) begin
            slot_v_ff[i] <= 1'b0;
            slot_d_ff[i] <= '0;
         end
         q_ff <= '0;
         oe_ff <= 1'b0;
      end else begin
         slot_v_ff <= nxt_slot_v;
         slot_d_ff <= nxt_slot_d;
         q_ff <= nxt_q;
         oe_ff <= nxt_oe;
      end
   end

   // ---------------- echo strobes ----------------
   logic echo_p_ff, echo_n_ff, nxt_echo_p, nxt_echo_n;

   always_comb begin
      nxt_echo_p = single_mode ? k_s : c_s; // [R14]
      nxt_echo_n = single_mode ? kn_s : cn_s;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         echo_p_ff <= 1'b0;
         echo_n_ff <= 1'b0;
      end else begin
         echo_p_ff <= nxt_echo_p;
         echo_n_ff <= nxt_echo_n;
      end
   end

   assign lnk.q = q_ff;
   assign lnk.q_oe = oe_ff;
   assign lnk.echo_strobe_p = echo_p_ff;
   assign lnk.echo_strobe_n = echo_n_ff;
endmodule : dps_mem_end
`default_nettype wire

// [src/dps_ctrl_end.sv]
// controller end: makes link clocks, issues bursts, collects read data
`timescale 1ns/1ps
`default_nettype none
module dps_ctrl_end
   import dps_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   dps_link_if.ctrl lnk,
   input wire logic single_clock,
   input wire logic pll_off,
   input wire logic rd_req,
   input wire logic [DPS_ADDR_W-1:0] rd_addr,
   output logic rd_ready,
   output logic rd_valid,
   output logic [DPS_DATA_W-1:0] rd_word0,
   output logic [DPS_DATA_W-1:0] rd_word1,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [DPS_ADDR_W-1:0] wr_addr,
   input wire logic [DPS_DATA_W-1:0] wr_word0,
   input wire logic [DPS_DATA_W-1:0] wr_word1,
   input wire logic [DPS_LANES-1:0] wr_lane0_n,
   input wire logic [DPS_LANES-1:0] wr_lane1_n
);
   logic fq_valid, fq_ready;
   logic [DPS_WR_W-1:0] fq_data;

   dps_fifo #(.W(DPS_WR_W), .DEPTH(DPS_FIFO_DEPTH)) u_wr_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data({wr_addr, wr_word0, wr_word1, wr_lane0_n, wr_lane1_n}),
      .out_valid(fq_valid),
      .out_ready(fq_ready),
      .out_data(fq_data)
   );

   logic [2:0] ph_ff, nxt_ph;
   logic pos_setup, neg_setup;
   assign pos_setup = (ph_ff == DPS_PH_POS_SETUP);
   assign neg_setup = (ph_ff == DPS_PH_NEG_SETUP);
   assign rd_ready = pos_setup; // [R9]
   assign fq_ready = pos_setup; // [R17]

   logic k_ff, c_ff, cn_ff, nxt_k;
   logic [DPS_ADDR_W-1:0] addr_ff, nxt_addr;
   logic rps_ff, wps_ff, nxt_rps, nxt_wps;
   logic [DPS_DATA_W-1:0] d_ff, nxt_d;
   logic [DPS_LANES-1:0] bws_ff, nxt_bws;
   logic [DPS_ADDR_W+DPS_DATA_W+DPS_LANES-1:0] hold_ff, nxt_hold;
   logic hold_v_ff, nxt_hold_v;

   always_comb begin
      nxt_ph = (ph_ff == DPS_PH_LAST) ? 3'h0 : 3'(ph_ff + 3'h1);
      nxt_k = (nxt_ph < DPS_K_HALF);
      nxt_addr = addr_ff;
      nxt_rps = rps_ff;
      nxt_wps = wps_ff;
      nxt_d = d_ff;
      nxt_bws = bws_ff;
      nxt_hold = hold_ff;
      nxt_hold_v = hold_v_ff;
      if (pos_setup) begin
         nxt_rps = ~rd_req; // [R9]
         nxt_addr = rd_req ? rd_addr : addr_ff; // [R4]
         nxt_wps = ~fq_valid; // [R17]
         nxt_hold_v = fq_valid;
         if (fq_valid) begin
            nxt_d = fq_data[2*DPS_LANES+DPS_DATA_W +: DPS_DATA_W]; // [R16] [R20]
            nxt_bws = fq_data[DPS_LANES +: DPS_LANES]; // [R3]
            nxt_hold = {fq_data[DPS_WR_W-1 -: DPS_ADDR_W],
                        fq_data[2*DPS_LANES +: DPS_DATA_W],
                        fq_data[0 +: DPS_LANES]};
         end
      end else if (neg_setup) begin
         nxt_rps = 1'b1;
         nxt_wps = 1'b1;
         if (hold_v_ff) begin
            {nxt_addr, nxt_d, nxt_bws} = hold_ff; // [R4] [R20] [R3]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ph_ff <= 3'h0;
         k_ff <= 1'b1;
         c_ff <= 1'b1;
         cn_ff <= 1'b0;
         addr_ff <= '0;
         rps_ff <= 1'b1;
         wps_ff <= 1'b1;
         d_ff <= '0;
         bws_ff <= '1;
         hold_ff <= '0;
         hold_v_ff <= 1'b0;
      end else begin
         ph_ff <= nxt_ph;
         k_ff <= nxt_k;
         // c pair moves with k unless single_clock holds both high, so board skew cancels [R15]
         c_ff <= single_clock | nxt_k;
         cn_ff <= single_clock | ~nxt_k;
         addr_ff <= nxt_addr;
         rps_ff <= nxt_rps;
         wps_ff <= nxt_wps;
         d_ff <= nxt_d;
         bws_ff <= nxt_bws;
         hold_ff <= nxt_hold;
         hold_v_ff <= nxt_hold_v;
      end
   end

   assign lnk.k = k_ff;
   assign lnk.k_n = ~k_ff;
   assign lnk.c = c_ff;
   assign lnk.c_n = cn_ff;
   assign lnk.addr = addr_ff;
   assign lnk.read_port_select_n = rps_ff;
   assign lnk.write_port_select_n = wps_ff;
   assign lnk.lane_write_enable_n = bws_ff;
   assign lnk.d = d_ff;
   assign lnk.pll_disable_n = ~pll_off; // [R18]

   // read capture: echo and data share one synchroniser path
   localparam int RW = DPS_DATA_W + 3;
   logic [RW-1:0] rmeta_ff, rsmp_ff;
   logic [1:0] echo_prev_ff;
   logic cap, word_sel_ff, nxt_word_sel, rv_ff, nxt_rv;
   logic [DPS_DATA_W-1:0] w0_ff, w1_ff, nxt_w0, nxt_w1;

   assign cap = rsmp_ff[DPS_DATA_W] &
                ((rsmp_ff[RW-1] & ~echo_prev_ff[1]) | (rsmp_ff[RW-2] & ~echo_prev_ff[0]));

   always_comb begin
      nxt_word_sel = rsmp_ff[DPS_DATA_W] ? word_sel_ff : 1'b0;
      nxt_w0 = w0_ff;
      nxt_w1 = w1_ff;
      nxt_rv = 1'b0;
      if (cap) begin
         nxt_word_sel = ~word_sel_ff;
         if (!word_sel_ff) begin
            nxt_w0 = rsmp_ff[DPS_DATA_W-1:0];
         end else begin
            nxt_w1 = rsmp_ff[DPS_DATA_W-1:0]; // [R11]
            nxt_rv = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rmeta_ff <= '0;
         rsmp_ff <= '0;
         echo_prev_ff <= 2'h0;
         word_sel_ff <= 1'b0;
         w0_ff <= '0;
         w1_ff <= '0;
         rv_ff <= 1'b0;
      end else begin
         rmeta_ff <= {lnk.echo_strobe_p, lnk.echo_strobe_n, lnk.q_oe, lnk.q};
         rsmp_ff <= rmeta_ff;
         echo_prev_ff <= rsmp_ff[RW-1 -: 2];
         word_sel_ff <= nxt_word_sel;
         w0_ff <= nxt_w0;
         w1_ff <= nxt_w1;
         rv_ff <= nxt_rv;
      end
   end

   assign rd_valid = rv_ff;
   assign rd_word0 = w0_ff;
   assign rd_word1 = w1_ff;
endmodule : dps_ctrl_end
`default_nettype wire

// [bench/dps_link_chk.sv]
// link pin assertions between the memory end and the controller end
`timescale 1ns/1ps
`default_nettype none
module dps_link_chk
   import dps_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic k,
   input wire logic k_n,
   input wire logic c,
   input wire logic c_n,
   input wire logic [DPS_ADDR_W-1:0] addr,
   input wire logic read_port_select_n,
   input wire logic write_port_select_n,
   input wire logic [DPS_LANES-1:0] lane_write_enable_n,
   input wire logic [DPS_DATA_W-1:0] d,
   input wire logic [DPS_DATA_W-1:0] q,
   input wire logic q_oe,
   input wire logic echo_strobe_p,
   input wire logic echo_strobe_n,
   input wire logic pll_disable_n
);
   logic [3:0] settle_ff;
   logic [3:0] nxt_settle;
   logic [5:0] rd_idle_ff;
   logic [5:0] nxt_rd_idle;

   // echo flops start from reset values, so hold off until they have flushed
   always_comb begin
      nxt_settle = (settle_ff == 4'hF) ? settle_ff : settle_ff + 4'h1;
      nxt_rd_idle = (rd_idle_ff == 6'h3F) ? rd_idle_ff : rd_idle_ff + 6'h01;
      if (!read_port_select_n) begin
         nxt_rd_idle = 6'h00;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         settle_ff <= 4'h0;
         rd_idle_ff <= 6'h00;
      end else begin
         settle_ff <= nxt_settle;
         rd_idle_ff <= nxt_rd_idle;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence k_high_half;
      k [*4];
   endsequence
   sequence k_low_half;
      !k [*4];
   endsequence
   sequence two_words;
      q_oe [*8];
   endsequence
   sequence dual_mode;
      (!(c && c_n)) [*8];
   endsequence
   sequence single_mode;
      (c && c_n) [*8];
   endsequence
   // read issued with no read in the k cycle before, so bursts do not merge
   sequence rd_issue;
      $rose(k) && !read_port_select_n && $past(read_port_select_n, 8);
   endsequence

   k_period_a: assert property ($rose(k) |-> k_high_half ##1 k_low_half ##1 k)
      else $error("link clock period or duty wrong");
   k_pair_a: assert property (k_n == !k)
      else $error("negative input clock not inverse of positive");
   c_pair_a: assert property (!(c && c_n) |-> (c == k) && (c_n == k_n))
      else $error("output clock pair not driven together");
   echo_pos_a: assert property (dual_mode ##0 settle_ff == 4'hF |-> echo_strobe_p == $past(c, 3))
      else $error("positive echo does not follow output clock");
   echo_neg_a: assert property (dual_mode ##0 settle_ff == 4'hF |-> echo_strobe_n == $past(c_n, 3))
      else $error("negative echo does not follow output clock");
   echo_single_a: assert property (single_mode ##0 settle_ff == 4'hF |->
      echo_strobe_p == $past(k, 3) && echo_strobe_n == $past(k_n, 3))
      else $error("echo does not follow input clock in single mode");
   q_release_a: assert property (rd_idle_ff >= 6'h28 |-> !q_oe)
      else $error("read data still driven with read port idle");
   burst_len_a: assert property ($rose(q_oe) |-> two_words)
      else $error("read burst shorter than two words");
   word_hold_a: assert property ($rose(q_oe) |=> $stable(q) [*3])
      else $error("first read word not held for a half period");
   rd_lat_pll_a: assert property (rd_issue ##0 pll_disable_n |-> ##15 $rose(q_oe))
      else $error("read latency wrong with pll on");
   rd_lat_nopll_a: assert property (rd_issue ##0 !pll_disable_n |-> ##11 $rose(q_oe))
      else $error("read latency wrong with pll off");
endmodule : dps_link_chk
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench: both link ends joined, user sides driven here
`timescale 1ns/1ps
`default_nettype none
module testbench
   import dps_pkg::*;
;
   logic clk, rst, single_clock, pll_off, rd_req, wr_valid, rd_ready, rd_valid, wr_ready;
   logic saw_full;
   logic [DPS_ADDR_W-1:0] rd_addr, wr_addr;
   logic [DPS_DATA_W-1:0] wr_word0, wr_word1, rd_word0, rd_word1;
   logic [DPS_LANES-1:0] wr_lane0_n, wr_lane1_n;
   int err_count, check_count;

   dps_link_if lnk ();
   dps_mem_end i_dps_mem_end (.clk(clk), .rst(rst), .lnk(lnk.mem));
   dps_ctrl_end i_dps_ctrl_end (.clk(clk), .rst(rst), .lnk(lnk.ctrl),
      .single_clock(single_clock), .pll_off(pll_off), .rd_req(rd_req), .rd_addr(rd_addr),
      .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_word0(rd_word0), .rd_word1(rd_word1),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_word0(wr_word0),
      .wr_word1(wr_word1), .wr_lane0_n(wr_lane0_n), .wr_lane1_n(wr_lane1_n));
   dps_link_chk i_dps_link_chk (.clk(clk), .rst(rst), .k(lnk.k), .k_n(lnk.k_n), .c(lnk.c),
      .c_n(lnk.c_n), .addr(lnk.addr), .read_port_select_n(lnk.read_port_select_n),
      .write_port_select_n(lnk.write_port_select_n), .d(lnk.d), .q(lnk.q),
      .lane_write_enable_n(lnk.lane_write_enable_n), .q_oe(lnk.q_oe),
      .echo_strobe_p(lnk.echo_strobe_p), .echo_strobe_n(lnk.echo_strobe_n),
      .pll_disable_n(lnk.pll_disable_n));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick

   task automatic chk_word(input logic [DPS_DATA_W-1:0] got, input logic [DPS_DATA_W-1:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      chk_word(DPS_DATA_W'(got), DPS_DATA_W'(exp));
   endtask : chk_bit

   task automatic close_out();
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out

   function automatic logic pick(input int sel);
      return (sel == 0) ? wr_ready : ((sel == 1) ? rd_ready : rd_valid);
   endfunction : pick

   // ready is settled mid-cycle and holds to the next rising edge
   task automatic wait_hi(input int sel, input int lim);
      int n;
      n = 0;
      @(negedge clk);
      while (!pick(sel) && n < lim) begin
         if (sel == 0) begin
            saw_full = 1'b1;
         end
         @(negedge clk);
         n++;
      end
      chk_bit(pick(sel), 1'b1);
   endtask : wait_hi

   function automatic logic [DPS_DATA_W-1:0] lane_bits(input logic [DPS_LANES-1:0] l_n);
      logic [DPS_DATA_W-1:0] m;
      m = '0;
      for (int i = 0; i < DPS_LANES; i++) begin
         if (!l_n[i]) begin
            m[i*DPS_LANE_W +: DPS_LANE_W] = '1;
         end
      end
      return m;
   endfunction : lane_bits

   task automatic do_reset();
      rst = 1'b1;
      repeat (20) tick();
      rst = 1'b0;
   endtask : do_reset

   task automatic wr_burst(input logic [DPS_ADDR_W-1:0] a, input logic [DPS_DATA_W-1:0] w0,
         input logic [DPS_DATA_W-1:0] w1, input logic [DPS_LANES-1:0] l0,
         input logic [DPS_LANES-1:0] l1);
      tick();
      wr_addr = a;
      wr_word0 = w0;
      wr_word1 = w1;
      wr_lane0_n = l0;
      wr_lane1_n = l1;
      wr_valid = 1'b1;
      wait_hi(0, 200);
      tick();
      wr_valid = 1'b0;
   endtask : wr_burst

   task automatic rd_burst(input logic [DPS_ADDR_W-1:0] a, input logic [DPS_DATA_W-1:0] e0,
         input logic [DPS_DATA_W-1:0] e1);
      tick();
      rd_addr = a;
      rd_req = 1'b1;
      wait_hi(1, 16);
      tick();
      rd_req = 1'b0;
      wait_hi(2, 200);
      chk_word(rd_word0, e0);
      chk_word(rd_word1, e1);
      tick();
   endtask : rd_burst

   // no forwarding: let queued writes reach the banks before reading back
   task automatic settle();
      repeat (64) tick();
   endtask : settle

   task automatic t_full();
      wr_burst(20'h00010, 36'h123456789, 36'hFEDCBA987, 4'h0, 4'h0);
      settle();
      rd_burst(20'h00010, 36'h123456789, 36'hFEDCBA987);
   endtask : t_full

   task automatic t_lanes();
      logic [DPS_DATA_W-1:0] e0, e1;
      logic [DPS_LANES-1:0] l0;
      e0 = 36'h000000000;
      e1 = 36'h000000000;
      wr_burst(20'h00222, e0, e1, 4'h0, 4'h0);
      // last pass has every lane deselected and must change nothing
      for (int i = 0; i <= DPS_LANES; i++) begin
         l0 = ~(4'h1 << i);
         e0 = e0 | lane_bits(l0);
         e1 = e1 | lane_bits({l0[0], l0[3:1]});
         wr_burst(20'h00222, 36'hFFFFFFFFF, 36'hFFFFFFFFF, l0, {l0[0], l0[3:1]});
         settle();
         rd_burst(20'h00222, e0, e1);
      end
   endtask : t_lanes

   task automatic t_fifo();
      saw_full = 1'b0;
      for (int j = 0; j < 6; j++) begin
         wr_burst(20'h00300 + 20'(j), 36'h100000000 + 36'(j), 36'h200000000 + 36'(j), 4'h0, 4'h0);
      end
      chk_bit(saw_full, 1'b1);
      settle();
      for (int j = 0; j < 6; j++) begin
         rd_burst(20'h00300 + 20'(j), 36'h100000000 + 36'(j), 36'h200000000 + 36'(j));
      end
   endtask : t_fifo

   task automatic t_modes();
      for (int m = 0; m < 2; m++) begin
         pll_off = (m == 0);
         single_clock = (m == 1);
         do_reset();
         wr_burst(20'hFFFFF, 36'hA5A5A5A5A, 36'h5A5A5A5A5, 4'h0, 4'h0);
         settle();
         rd_burst(20'hFFFFF, 36'hA5A5A5A5A, 36'h5A5A5A5A5);
      end
      pll_off = 1'b0;
      single_clock = 1'b0;
      do_reset();
      rd_burst(20'h00010, 36'h123456789, 36'hFEDCBA987);
   endtask : t_modes

   initial begin
      rst = 1'b1;
      single_clock = 1'b0;
      pll_off = 1'b0;
      rd_req = 1'b0;
      rd_addr = 20'h00000;
      wr_valid = 1'b0;
      wr_addr = 20'h00000;
      wr_word0 = 36'h000000000;
      wr_word1 = 36'h000000000;
      wr_lane0_n = 4'hF;
      wr_lane1_n = 4'hF;
      saw_full = 1'b0;
      err_count = 0;
      check_count = 0;
      do_reset();
      t_full();
      t_lanes();
      t_fifo();
      t_modes();
      close_out();
   end

   // whole run is well under two thousand cycles; this only trips on a hang
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      close_out();
   end
endmodule : testbench
`default_nettype wire
